// [rtl/ppi_pkg.sv]
// shared constants, register map and carrier types for the port pin interrupt block
package ppi_pkg;

    // widths
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned P1_W   = 8;
    localparam int unsigned P2_W   = 5;
    localparam int unsigned EVT_W  = 2;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_P1_FLAGS   = 8'h8A;
    localparam logic [ADDR_W-1:0] OFS_P2_FLAGS   = 8'h8B;
    localparam logic [ADDR_W-1:0] OFS_CTRL       = 8'h8C;
    localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 8'h90;
    localparam logic [ADDR_W-1:0] OFS_EVT_MASK   = 8'h91;

    // reset and fixed read values
    localparam logic [DATA_W-1:0] READ_ZERO    = 8'h00;
    localparam logic [P1_W-1:0]   P1_FLAGS_RST = 8'h00;
    localparam logic [P2_W-1:0]   P2_FLAGS_RST = 5'h00;
    localparam logic [EVT_W-1:0]  EVT_RST      = 2'h0;
    localparam logic [2:0]        P2_HIGH_ZERO = 3'h0;

    // event status bit positions
    localparam int unsigned EVT_P1_BIT = 0;
    localparam int unsigned EVT_P2_BIT = 1;

    // edge select codes
    localparam logic EDGE_RISE = 1'h0;
    localparam logic EDGE_FALL = 1'h1;

    // register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } ppi_bus_req_t;

    // port interrupt control register layout
    typedef struct packed {
        logic       unused_hi;
        logic       drive_strength_select;
        logic       port2_irq_enable;
        logic       port0_upper_irq_enable;
        logic       port0_lower_irq_enable;
        logic       port2_edge_select;
        logic [1:0] unused_lo;
    } ppi_ctrl_t;

    localparam ppi_ctrl_t CTRL_RST = 8'h00;

    // top-level state
    typedef struct packed {
        ppi_ctrl_t         ctrl;
        logic [EVT_W-1:0]  evt_status;
        logic [EVT_W-1:0]  evt_mask;
        logic [DATA_W-1:0] rdata;
        logic              irq;
    } ppi_state_t;

    // address match
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
        return addr == ofs;
    endfunction

    // control write image, fixed bits forced to zero
    function automatic ppi_ctrl_t ctrl_from_wdata(input logic [DATA_W-1:0] wdata);
        ppi_ctrl_t c;
        c           = ppi_ctrl_t'(wdata);
        c.unused_hi = 1'h0;
        c.unused_lo = 2'h0;
        return c;
    endfunction

endpackage

// [rtl/ppi_edge_det.sv]
// edge detector for a group of port inputs with selectable polarity
`timescale 1ns/1ps
module ppi_edge_det #(
    parameter int unsigned W = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // pins and polarity
    input  wire logic [W-1:0] pins,
    input  wire logic         fall_sel,
    // one-cycle edge pulses
    output logic      [W-1:0] edge_pulse
);

    typedef struct packed {
        logic [W-1:0] prev;
        logic         primed;
    } ppi_edge_state_t;

    ppi_edge_state_t st_q;
    ppi_edge_state_t st_d;

    always_comb begin
        st_d        = st_q;
        st_d.prev   = pins;
        st_d.primed = 1'h1;
        // no edge before the first sample after reset
        if (!st_q.primed) begin
            edge_pulse = '0;
        end else if (fall_sel == ppi_pkg::EDGE_FALL) begin
            edge_pulse = st_q.prev & ~pins; // [RULE_09]
        end else begin
            edge_pulse = ~st_q.prev & pins; // [RULE_07]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_EDGE_RISE: assert property ( // [RULE_07]
        (fall_sel == ppi_pkg::EDGE_RISE) && st_q.primed |-> edge_pulse == (~$past(pins) & pins))
        else $error("rising edge not reported");

    AST_EDGE_FALL: assert property ( // [RULE_09]
        (fall_sel == ppi_pkg::EDGE_FALL) && st_q.primed |-> edge_pulse == ($past(pins) & ~pins))
        else $error("falling edge not reported");

endmodule // ppi_edge_det

// [rtl/ppi_flag_bank.sv]
// sticky pending flags, written zero clears, hardware set wins
`timescale 1ns/1ps
module ppi_flag_bank #(
    parameter int unsigned W = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // hardware set and software write
    input  wire logic [W-1:0] set,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wdata,
    // flags
    output logic      [W-1:0] flags_q
);

    typedef struct packed {
        logic [W-1:0] flags;
    } ppi_flag_state_t;

    ppi_flag_state_t st_q;
    ppi_flag_state_t st_d;

    always_comb begin
        st_d = st_q;
        if (wr_en) begin
            st_d.flags = st_q.flags & wdata; // [RULE_10]
        end
        st_d.flags = st_d.flags | set; // [RULE_01] [RULE_02]
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flags_q = st_q.flags;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_W0_CLEAR: assert property ( // [RULE_10]
        wr_en |=> (flags_q & ~$past(wdata) & ~$past(set)) == '0)
        else $error("written zero did not clear flag");

    AST_W1_KEEP: assert property ( // [RULE_10]
        wr_en |=> ((flags_q ^ $past(flags_q)) & $past(wdata) & ~$past(set)) == '0)
        else $error("written one changed a flag");

    AST_SET_WINS: assert property ( // [RULE_01]
        |set |=> (flags_q & $past(set)) == $past(set))
        else $error("pending request lost");

endmodule // ppi_flag_bank

// [rtl/ppi_port_irq.sv]
// port pin interrupt flags, control register and interrupt output
//
// What this block does
// [RULE_01] eight port 1 pending flags, reset zero
// [RULE_02] five port 2 flags, bits 7:5 zero
// [RULE_03] control bit 6 selects output drive strength
// [RULE_04] control bit 5 enables port 2 requests
// [RULE_05] control bit 4 enables port 0 upper requests
// [RULE_06] control bit 3 enables port 0 lower requests
// [RULE_07] control bit 2 zero: rising edge requests
// [RULE_08] control bit 7 reads zero, ignores writes
// [RULE_09] edge select one: falling edge requests instead
// [RULE_10] writing zero clears flag, one keeps it
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module ppi_port_irq (
    // clock and reset
    input  wire logic                             clk,
    input  wire logic                             rst_n,
    // register bus
    input  wire ppi_pkg::ppi_bus_req_t            bus_req,
    output logic      [ppi_pkg::DATA_W-1:0]       bus_rdata,
    // port inputs
    input  wire logic [ppi_pkg::P1_W-1:0]         port1_pins,
    input  wire logic [ppi_pkg::P2_W-1:0]         port2_pins,
    // control outputs
    output logic                                  drive_strength_select,
    output logic                                  port0_upper_irq_enable,
    output logic                                  port0_lower_irq_enable,
    // interrupt
    output logic                                  irq
);

    ppi_pkg::ppi_state_t          st_q;
    ppi_pkg::ppi_state_t          st_d;

    logic [ppi_pkg::P1_W-1:0]     p1_set;
    logic [ppi_pkg::P2_W-1:0]     p2_set;
    logic [ppi_pkg::P1_W-1:0]     p1_flags;
    logic [ppi_pkg::P2_W-1:0]     p2_flags;
    logic                         p1_wr;
    logic                         p2_wr;
    logic                         ctrl_wr;
    logic                         stat_wr;
    logic                         mask_wr;
    logic [ppi_pkg::EVT_W-1:0]    evt_now;
    ppi_pkg::ppi_ctrl_t           wr_img;

    // write decode
    assign p1_wr   = bus_req.wr && ppi_pkg::hit(bus_req.addr, ppi_pkg::OFS_P1_FLAGS);
    assign p2_wr   = bus_req.wr && ppi_pkg::hit(bus_req.addr, ppi_pkg::OFS_P2_FLAGS);
    assign ctrl_wr = bus_req.wr && ppi_pkg::hit(bus_req.addr, ppi_pkg::OFS_CTRL);
    assign stat_wr = bus_req.wr && ppi_pkg::hit(bus_req.addr, ppi_pkg::OFS_EVT_STATUS);
    assign mask_wr = bus_req.wr && ppi_pkg::hit(bus_req.addr, ppi_pkg::OFS_EVT_MASK);
    assign wr_img  = ppi_pkg::ppi_ctrl_t'(bus_req.wdata);

    // port 1 edges, fixed rising
    ppi_edge_det #(
        .W          (ppi_pkg::P1_W)
    ) u_p1_edge (
        .clk        (clk),
        .rst_n      (rst_n),
        .pins       (port1_pins),
        .fall_sel   (ppi_pkg::EDGE_RISE),
        .edge_pulse (p1_set)
    );

    // port 2 edges, polarity from control
    ppi_edge_det #(
        .W          (ppi_pkg::P2_W)
    ) u_p2_edge (
        .clk        (clk),
        .rst_n      (rst_n),
        .pins       (port2_pins),
        .fall_sel   (st_q.ctrl.port2_edge_select), // [RULE_07] [RULE_09]
        .edge_pulse (p2_set)
    );

    // port 1 pending flags
    ppi_flag_bank #(
        .W       (ppi_pkg::P1_W)
    ) u_p1_flags (
        .clk     (clk),
        .rst_n   (rst_n),
        .set     (p1_set), // [RULE_01]
        .wr_en   (p1_wr),
        .wdata   (bus_req.wdata),
        .flags_q (p1_flags)
    );

    // port 2 pending flags
    ppi_flag_bank #(
        .W       (ppi_pkg::P2_W)
    ) u_p2_flags (
        .clk     (clk),
        .rst_n   (rst_n),
        .set     (p2_set), // [RULE_02]
        .wr_en   (p2_wr),
        .wdata   (bus_req.wdata[ppi_pkg::P2_W-1:0]),
        .flags_q (p2_flags)
    );

    // request events into the sticky status
    always_comb begin
        evt_now                      = ppi_pkg::EVT_RST;
        evt_now[ppi_pkg::EVT_P1_BIT] = |p1_set;
        evt_now[ppi_pkg::EVT_P2_BIT] = (|p2_set) && st_q.ctrl.port2_irq_enable; // [RULE_04]
    end

    always_comb begin
        st_d       = st_q;
        st_d.rdata = ppi_pkg::READ_ZERO;
        // control register, fixed bits held at zero
        if (ctrl_wr) begin
            st_d.ctrl = ppi_pkg::ctrl_from_wdata(bus_req.wdata); // [RULE_03] [RULE_05] [RULE_06] [RULE_08]
        end
        // status: write one clears, new event wins
        if (stat_wr) begin
            st_d.evt_status = st_q.evt_status & ~bus_req.wdata[ppi_pkg::EVT_W-1:0];
        end
        st_d.evt_status = st_d.evt_status | evt_now;
        if (mask_wr) begin
            st_d.evt_mask = bus_req.wdata[ppi_pkg::EVT_W-1:0];
        end
        st_d.irq = |(st_d.evt_status & st_d.evt_mask);
        // read mux, unmapped reads zero
        if (bus_req.rd) begin
            unique case (1'h1)
                ppi_pkg::hit(bus_req.addr, ppi_pkg::OFS_P1_FLAGS): begin
                    st_d.rdata = p1_flags;
                end
                ppi_pkg::hit(bus_req.addr, ppi_pkg::OFS_P2_FLAGS): begin
                    st_d.rdata = {ppi_pkg::P2_HIGH_ZERO, p2_flags}; // [RULE_02]
                end
                ppi_pkg::hit(bus_req.addr, ppi_pkg::OFS_CTRL): begin
                    st_d.rdata = st_q.ctrl; // [RULE_08]
                end
                ppi_pkg::hit(bus_req.addr, ppi_pkg::OFS_EVT_STATUS): begin
                    st_d.rdata[ppi_pkg::EVT_W-1:0] = st_q.evt_status;
                end
                ppi_pkg::hit(bus_req.addr, ppi_pkg::OFS_EVT_MASK): begin
                    st_d.rdata[ppi_pkg::EVT_W-1:0] = st_q.evt_mask;
                end
                default: begin
                    st_d.rdata = ppi_pkg::READ_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from state flops
    assign bus_rdata              = st_q.rdata;
    assign irq                    = st_q.irq;
    assign drive_strength_select  = st_q.ctrl.drive_strength_select; // [RULE_03]
    assign port0_upper_irq_enable = st_q.ctrl.port0_upper_irq_enable; // [RULE_05]
    assign port0_lower_irq_enable = st_q.ctrl.port0_lower_irq_enable; // [RULE_06]

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_P1_READ: assert property ( // [RULE_01]
        bus_req.rd && ppi_pkg::hit(bus_req.addr, ppi_pkg::OFS_P1_FLAGS) |=> bus_rdata == $past(p1_flags))
        else $error("port 1 flag read wrong");

    AST_P2_HIGH_ZERO: assert property ( // [RULE_02]
        bus_req.rd && ppi_pkg::hit(bus_req.addr, ppi_pkg::OFS_P2_FLAGS)
        |=> bus_rdata == {ppi_pkg::P2_HIGH_ZERO, $past(p2_flags)})
        else $error("port 2 flag read wrong");

    AST_DRIVE: assert property ( // [RULE_03]
        ctrl_wr |=> drive_strength_select == $past(wr_img.drive_strength_select))
        else $error("drive select not taken");

    AST_P2_GATE: assert property ( // [RULE_04]
        !st_q.ctrl.port2_irq_enable && !st_q.evt_status[ppi_pkg::EVT_P2_BIT]
        |=> !st_q.evt_status[ppi_pkg::EVT_P2_BIT])
        else $error("port 2 request passed while disabled");

    AST_P2_REQ: assert property ( // [RULE_04]
        st_q.ctrl.port2_irq_enable && (|p2_set) |=> st_q.evt_status[ppi_pkg::EVT_P2_BIT])
        else $error("enabled port 2 request lost");

    AST_P0_UPPER: assert property ( // [RULE_05]
        ctrl_wr |=> port0_upper_irq_enable == $past(wr_img.port0_upper_irq_enable))
        else $error("port 0 upper enable not taken");

    AST_P0_LOWER: assert property ( // [RULE_06]
        ctrl_wr |=> port0_lower_irq_enable == $past(wr_img.port0_lower_irq_enable))
        else $error("port 0 lower enable not taken");

    AST_EDGE_SEL: assert property ( // [RULE_07]
        ctrl_wr |=> st_q.ctrl.port2_edge_select == $past(wr_img.port2_edge_select))
        else $error("edge select not taken");

    AST_CTRL_BIT7: assert property ( // [RULE_08]
        bus_req.rd && ppi_pkg::hit(bus_req.addr, ppi_pkg::OFS_CTRL) |=> !bus_rdata[ppi_pkg::DATA_W-1])
        else $error("unused control bit reads one");

    AST_P2_FALL: assert property ( // [RULE_09]
        st_q.ctrl.port2_edge_select && ($past(port2_pins) & ~port2_pins) != '0
        && $past(st_q.ctrl.port2_edge_select) |=> (p2_flags & $past(port2_pins, 2) & ~$past(port2_pins)) != '0)
        else $error("falling edge did not set port 2 flag");

    AST_P1_CLEAR: assert property ( // [RULE_10]
        p1_wr && !(|p1_set) |=> p1_flags == ($past(p1_flags) & $past(bus_req.wdata)))
        else $error("port 1 flag write wrong");

    AST_IRQ_LEVEL: assert property (
        irq == |(st_q.evt_status & st_q.evt_mask))
        else $error("interrupt output disagrees with status and mask");

    AST_RST_P1: assert property ( // [RULE_01]
        $rose(rst_n) |-> p1_flags == ppi_pkg::P1_FLAGS_RST)
        else $error("port 1 flags not cleared by reset");

    AST_RST_P2: assert property ( // [RULE_02]
        $rose(rst_n) |-> p2_flags == ppi_pkg::P2_FLAGS_RST)
        else $error("port 2 flags not cleared by reset");

    AST_RST_DRIVE: assert property ( // [RULE_03]
        $rose(rst_n) |-> drive_strength_select == ppi_pkg::CTRL_RST.drive_strength_select)
        else $error("drive select not cleared by reset");

    AST_RST_P2_EN: assert property ( // [RULE_04]
        $rose(rst_n) |-> st_q.ctrl.port2_irq_enable == ppi_pkg::CTRL_RST.port2_irq_enable)
        else $error("port 2 enable not cleared by reset");

    AST_RST_P0_UP: assert property ( // [RULE_05]
        $rose(rst_n) |-> port0_upper_irq_enable == ppi_pkg::CTRL_RST.port0_upper_irq_enable)
        else $error("port 0 upper enable not cleared by reset");

    AST_RST_P0_LO: assert property ( // [RULE_06]
        $rose(rst_n) |-> port0_lower_irq_enable == ppi_pkg::CTRL_RST.port0_lower_irq_enable)
        else $error("port 0 lower enable not cleared by reset");

    AST_RST_EDGE: assert property ( // [RULE_07]
        $rose(rst_n) |-> st_q.ctrl.port2_edge_select == ppi_pkg::CTRL_RST.port2_edge_select)
        else $error("edge select not cleared by reset");

    AST_RST_IRQ: assert property (
        $rose(rst_n) |-> !irq && st_q.evt_status == ppi_pkg::EVT_RST)
        else $error("interrupt state not cleared by reset");

    AST_P1_RISE: assert property ( // [RULE_01]
        $past(rst_n) |=> ((~$past(port1_pins, 2) & $past(port1_pins)) & ~p1_flags) == '0)
        else $error("port 1 rising edge did not set flag");

    AST_P1_ONLY_RISE: assert property ( // [RULE_01]
        $past(rst_n)
        |=> (p1_flags & ~$past(p1_flags) & ~(~$past(port1_pins, 2) & $past(port1_pins))) == '0)
        else $error("port 1 flag set without rising edge");

    AST_P2_RISE: assert property ( // [RULE_07]
        $past(rst_n) && st_q.ctrl.port2_edge_select == ppi_pkg::EDGE_RISE
        |=> ((~$past(port2_pins, 2) & $past(port2_pins)) & ~p2_flags) == '0)
        else $error("port 2 rising edge did not set flag");

    AST_P2_ONLY_RISE: assert property ( // [RULE_07]
        st_q.ctrl.port2_edge_select == ppi_pkg::EDGE_RISE
        |=> (p2_flags & ~$past(p2_flags) & ~(~$past(port2_pins, 2) & $past(port2_pins))) == '0)
        else $error("port 2 flag set without rising edge");

    AST_P2_ONLY_FALL: assert property ( // [RULE_09]
        st_q.ctrl.port2_edge_select == ppi_pkg::EDGE_FALL
        |=> (p2_flags & ~$past(p2_flags) & ~($past(port2_pins, 2) & ~$past(port2_pins))) == '0)
        else $error("port 2 flag set without falling edge");

    AST_P2_CLEAR: assert property ( // [RULE_10]
        p2_wr && !(|p2_set) |=> p2_flags == ($past(p2_flags) & $past(bus_req.wdata[ppi_pkg::P2_W-1:0])))
        else $error("port 2 flag write wrong");

    AST_P1_HOLD: assert property ( // [RULE_01]
        !p1_wr && !(|p1_set) |=> $stable(p1_flags))
        else $error("port 1 flag changed without cause");

    AST_P2_HOLD: assert property ( // [RULE_02]
        !p2_wr && !(|p2_set) |=> $stable(p2_flags))
        else $error("port 2 flag changed without cause");

    AST_P2_EN_WR: assert property ( // [RULE_04]
        ctrl_wr |=> st_q.ctrl.port2_irq_enable == $past(wr_img.port2_irq_enable))
        else $error("port 2 enable not taken");

    AST_CTRL_HOLD: assert property ( // [RULE_03]
        !ctrl_wr |=> $stable(st_q.ctrl))
        else $error("control changed without write");

    AST_BIT7_HELD: assert property ( // [RULE_08]
        !st_q.ctrl.unused_hi)
        else $error("unused control bit stored");

    AST_CTRL_READ: assert property ( // [RULE_03]
        bus_req.rd && ppi_pkg::hit(bus_req.addr, ppi_pkg::OFS_CTRL)
        |=> bus_rdata == $past(st_q.ctrl))
        else $error("control read wrong");

    AST_P1_EVT: assert property (
        |p1_set |=> st_q.evt_status[ppi_pkg::EVT_P1_BIT])
        else $error("port 1 event lost");

    AST_P1_EVT_HOLD: assert property (
        !(|p1_set) && !stat_wr |=> $stable(st_q.evt_status[ppi_pkg::EVT_P1_BIT]))
        else $error("port 1 event changed without cause");

    AST_STAT_CLEAR: assert property (
        stat_wr && !(|evt_now) |=> (st_q.evt_status & $past(bus_req.wdata[ppi_pkg::EVT_W-1:0])) == '0)
        else $error("written one did not clear event");

    AST_MASK_WR: assert property (
        mask_wr |=> st_q.evt_mask == $past(bus_req.wdata[ppi_pkg::EVT_W-1:0]))
        else $error("mask not taken");

    AST_MASK_HOLD: assert property (
        !mask_wr |=> $stable(st_q.evt_mask))
        else $error("mask changed without write");

    AST_RDATA_IDLE: assert property (
        !bus_req.rd |=> bus_rdata == ppi_pkg::READ_ZERO)
        else $error("read data not zero without read");

    AST_STAT_READ: assert property (
        bus_req.rd && ppi_pkg::hit(bus_req.addr, ppi_pkg::OFS_EVT_STATUS)
        |=> bus_rdata[ppi_pkg::EVT_W-1:0] == $past(st_q.evt_status)
        && bus_rdata[ppi_pkg::DATA_W-1:ppi_pkg::EVT_W] == '0)
        else $error("event status read wrong");

    AST_MASK_READ: assert property (
        bus_req.rd && ppi_pkg::hit(bus_req.addr, ppi_pkg::OFS_EVT_MASK)
        |=> bus_rdata[ppi_pkg::EVT_W-1:0] == $past(st_q.evt_mask)
        && bus_rdata[ppi_pkg::DATA_W-1:ppi_pkg::EVT_W] == '0)
        else $error("event mask read wrong");

    AST_UNMAPPED_READ: assert property (
        bus_req.rd
        && !ppi_pkg::hit(bus_req.addr, ppi_pkg::OFS_P1_FLAGS)
        && !ppi_pkg::hit(bus_req.addr, ppi_pkg::OFS_P2_FLAGS)
        && !ppi_pkg::hit(bus_req.addr, ppi_pkg::OFS_CTRL)
        && !ppi_pkg::hit(bus_req.addr, ppi_pkg::OFS_EVT_STATUS)
        && !ppi_pkg::hit(bus_req.addr, ppi_pkg::OFS_EVT_MASK)
        |=> bus_rdata == ppi_pkg::READ_ZERO)
        else $error("unmapped read not zero");

endmodule // ppi_port_irq

// [dv/ppi_cpu_model.sv]
// register bus master model standing in for the cpu
`timescale 1ns/1ps
module ppi_cpu_model (
    // clock
    input  wire logic                       clk,
    // register bus
    output ppi_pkg::ppi_bus_req_t           bus_req,
    input  wire logic [ppi_pkg::DATA_W-1:0] bus_rdata
);
    initial bus_req = '0;

    // one strobe cycle, then released with inverted address and data
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w, output logic [7:0] q);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clk);
        bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
        #1;
        q = bus_rdata;
    endtask
endmodule // ppi_cpu_model

// [dv/tb_top.sv]
// self-checking testbench of the port pin interrupt block
`timescale 1ns/1ps
module tb_top;
    logic                  clk = 1'b0;
    logic                  rst_n = 1'b0;
    ppi_pkg::ppi_bus_req_t bus_req;
    logic [7:0]            bus_rdata;
    logic [7:0]            p1 = 8'h00;
    logic [4:0]            p2 = 5'h00;
    logic                  drv;
    logic                  up;
    logic                  lo;
    logic                  irq;
    int                    err_total = 0;
    int                    check_count = 0;

    always #2 clk = ~clk;

    ppi_port_irq i_dut (
        .clk(clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .port1_pins(p1), .port2_pins(p2), .drive_strength_select(drv),
        .port0_upper_irq_enable(up), .port0_lower_irq_enable(lo), .irq(irq)
    );
    ppi_cpu_model i_cpu (.clk(clk), .bus_req(bus_req), .bus_rdata(bus_rdata));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        i_cpu.xfer(a, d, 1'b1, q);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        i_cpu.xfer(a, 8'h00, 1'b0, q);
        chk(q, e);
    endtask

    task automatic pins(input logic [7:0] a, input logic [4:0] b);
        @(posedge clk);
        p1 <= a;
        p2 <= b;
        @(posedge clk);
        #1;
    endtask

    task automatic irqc(input logic e);
        @(posedge clk);
        #1;
        chk({7'h00, irq}, {7'h00, e});
    endtask

    task automatic t_reset();
        rdc(8'h8A, 8'h00);
        rdc(8'h8B, 8'h00);
        rdc(8'h8C, 8'h00);
        rdc(8'h90, 8'h00);
        rdc(8'h91, 8'h00);
        rdc(8'h55, 8'h00);
        chk({4'h0, drv, up, lo, irq}, 8'h00);
    endtask

    task automatic t_ctrl();
        logic [7:0] e;
        wr(8'h55, 8'hFF);
        for (int b = 0; b < 8; b++) begin
            e = (8'h01 << b) & 8'h7C;
            wr(8'h8C, 8'h01 << b);
            rdc(8'h8C, e);
            chk({5'h00, drv, up, lo}, {5'h00, e[6], e[4], e[3]});
        end
        wr(8'h8C, 8'hFF);
        rdc(8'h8C, 8'h7C);
        wr(8'h8C, 8'h00);
    endtask

    task automatic t_port1();
        pins(8'hA5, 5'h00);
        rdc(8'h8A, 8'hA5);
        rdc(8'h90, 8'h01);
        wr(8'h8A, 8'h0F);
        rdc(8'h8A, 8'h05);
        pins(8'h00, 5'h00);
        rdc(8'h8A, 8'h05);
        wr(8'h8A, 8'h00);
        wr(8'h90, 8'h01);
        rdc(8'h8A, 8'h00);
        rdc(8'h90, 8'h00);
    endtask

    task automatic t_irq();
        wr(8'h91, 8'h02);
        rdc(8'h91, 8'h02);
        wr(8'h8C, 8'h20);
        pins(8'h00, 5'h01);
        irqc(1'b1);
        rdc(8'h8B, 8'h01);
        wr(8'h8B, 8'h1E);
        rdc(8'h8B, 8'h00);
        irqc(1'b1);
        wr(8'h91, 8'h00);
        irqc(1'b0);
        wr(8'h91, 8'h02);
        irqc(1'b1);
        wr(8'h90, 8'h02);
        irqc(1'b0);
        pins(8'h00, 5'h1F);
        rdc(8'h8B, 8'h1E);
        wr(8'h8B, 8'h00);
        wr(8'h90, 8'h02);
    endtask

    task automatic t_edge();
        pins(8'h00, 5'h00);
        rdc(8'h8B, 8'h00);
        wr(8'h8C, 8'h24);
        pins(8'h00, 5'h1F);
        rdc(8'h8B, 8'h00);
        pins(8'h00, 5'h0A);
        rdc(8'h8B, 8'h15);
        rdc(8'h90, 8'h02);
        wr(8'h8B, 8'h00);
        wr(8'h90, 8'h02);
        wr(8'h8C, 8'h04);
        pins(8'h00, 5'h00);
        rdc(8'h8B, 8'h0A);
        rdc(8'h90, 8'h00);
        irqc(1'b0);
    endtask

    task automatic t_setwins();
        pins(8'h00, 5'h1F);
        fork
            wr(8'h8B, 8'h00);
            pins(8'h00, 5'h1E);
        join
        rdc(8'h8B, 8'h01);
    endtask

    task automatic t_rerst();
        wr(8'h8C, 8'h78);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rdc(8'h8B, 8'h00);
        rdc(8'h8C, 8'h00);
        chk({5'h00, drv, up, lo}, 8'h00);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_ctrl();
        t_port1();
        t_irq();
        t_edge();
        t_setwins();
        t_rerst();
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        complete_run();
    end
endmodule // tb_top
